//--- hdl/pds_sequencer.sv
/*
  pds_sequencer: ordered rail shutdown after rails-active falls, supply and
  thermal fault capture, filtered power-good and the latched event output.
  Assumes rail enables, rails-active and the register port come from logic
  on mclk; comparator and pushbutton levels are asynchronous pins.
*/
`timescale 1ns/1ps

module pds_sequencer
  import pds_pkg::*;
#(
  parameter int unsigned STEP_CYCLES     = pds_pkg::STEP_CYC,
  parameter int unsigned FILTER_CYCLES   = pds_pkg::FILTER_CYC,
  parameter int unsigned HOLD_CYCLES     = pds_pkg::HOLD_CYC,
  parameter int unsigned PERSIST_CYCLES  = pds_pkg::PERSIST_CYC,
  parameter int unsigned PB_CLEAR_CYCLES = pds_pkg::PB_CLEAR_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       railsActive,
  input  wire logic [7:0] railEnReq,
  output logic      [7:0] railEn,
  input  wire logic       supplyUndervoltage,
  input  wire logic       dieOvertemperature,
  output logic            faultStandby,
  output logic      [2:0] uvWarnSel,
  output logic      [1:0] otWarnSel,
  input  wire logic [7:0] railAbove93,
  input  wire logic [7:0] railBelow92,
  output logic            powerGoodOe,
  input  wire logic       pushButton_n,
  output logic            irq_n,
  input  wire logic       regWrEn,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       eventClearCmd
);
  import pds_pkg::*;

  // pin synchronisers, stage one read only by stage two
  // reset to idle levels: a released button must not look pressed
  logic [18:0] syncA_ff, syncB_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff <= 19'h00000;
      syncB_ff <= 19'h00000;
    end else begin
      syncA_ff <= {railBelow92, railAbove93, dieOvertemperature,
                   supplyUndervoltage, ~pushButton_n};
      syncB_ff <= syncA_ff;
    end
  end
  logic       pbLow, uvFault, otFault;
  logic [7:0] above93, below92;
  assign pbLow   = syncB_ff[0];
  assign uvFault = syncB_ff[1];
  assign otFault = syncB_ff[2];
  assign above93 = syncB_ff[10:3];
  assign below92 = syncB_ff[18:11];

  // delay code of a rail; the always-on rail and ones unsequenced give 0
  function automatic logic [1:0] delayCode(input logic [7:0] bucks,
                                           input logic [7:0] lins,
                                           input int unsigned idx);
    logic [1:0] code;
    code = 2'h0;
    if (idx < 4) code = bucks[2*idx +: 2];
    else if (idx >= LINEAR_FIRST)
      code = lins[2*(idx-LINEAR_FIRST) +: 2];
    return code;
  endfunction

  // registers written by software
  logic [7:0] seqBucks_ff, seqLin_ff, ctrl_ff, mask_ff;
  logic [7:0] nxt_seqBucks, nxt_seqLin, nxt_ctrl, nxt_mask;
  always_comb begin
    nxt_seqBucks = seqBucks_ff;
    nxt_seqLin   = seqLin_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_mask     = mask_ff;
    if (regWrEn) begin
      case (regAddr)
        REG_SEQ_BUCKS:   nxt_seqBucks = regWrData;
        REG_SEQ_LINEARS: nxt_seqLin   = {2'h0, regWrData[5:0]};
        REG_SYS_CONTROL: nxt_ctrl     = regWrData;
        REG_POWER_MASK:  nxt_mask     = regWrData;
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seqBucks_ff <= SEQ_RESET;
      seqLin_ff   <= SEQ_RESET;
      ctrl_ff     <= CTRL_RESET;
      mask_ff     <= MASK_RESET;
    end else begin
      seqBucks_ff <= nxt_seqBucks;
      seqLin_ff   <= nxt_seqLin;
      ctrl_ff     <= nxt_ctrl;
      mask_ff     <= nxt_mask;
    end
  end

  // down sequence: 100 ms steps counted from the rails-active fall
  pds_seq_t   seqSt_ff, nxt_seqSt;
  logic       activeDly_ff, nxt_activeDly;
  logic [31:0] tick_ff, nxt_tick;
  logic [1:0] step_ff, nxt_step;
  logic [7:0] held_ff, nxt_held, railEn_ff, nxt_railEn;
  always_comb begin
    nxt_seqSt     = seqSt_ff;
    nxt_activeDly = railsActive;
    nxt_tick      = tick_ff;
    nxt_step      = step_ff;
    nxt_held      = held_ff;
    nxt_railEn    = railEnReq;
    if (activeDly_ff && !railsActive) begin
      nxt_seqSt = SEQ_RUN;
      nxt_held  = railEnReq;
      nxt_tick  = 32'h0;
      nxt_step  = 2'h0;
    end else if (seqSt_ff == SEQ_RUN) begin
      case (seqSt_ff)
        SEQ_RUN: begin
          if (tick_ff == STEP_CYCLES - 1) begin
            nxt_tick = 32'h0;
            nxt_step = step_ff + 2'h1;
            if (step_ff == LAST_STEP - 2'h1) nxt_seqSt = SEQ_IDLE;
          end else begin
            nxt_tick = tick_ff + 32'h1;
          end
        end
        default: nxt_seqSt = SEQ_IDLE;
      endcase
    end
    if (railsActive) begin
      nxt_seqSt = SEQ_IDLE;
    end else begin
      for (int i = 0; i < NUM_RAILS; i++) begin
        if (i != ALWAYS_ON_RAIL)
          nxt_railEn[i] = (activeDly_ff ? railEnReq[i] : held_ff[i]) &
            (delayCode(seqBucks_ff, seqLin_ff, i) > nxt_step) &
            (nxt_seqSt == SEQ_RUN);
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seqSt_ff     <= SEQ_IDLE;
      activeDly_ff <= 1'b0;
      tick_ff      <= 32'h0;
      step_ff      <= 2'h0;
      held_ff      <= 8'h00;
      railEn_ff    <= 8'h00;
    end else begin
      seqSt_ff     <= nxt_seqSt;
      activeDly_ff <= nxt_activeDly;
      tick_ff      <= nxt_tick;
      step_ff      <= nxt_step;
      held_ff      <= nxt_held;
      railEn_ff    <= nxt_railEn;
    end
  end

  // per-rail low filter and hold-off timers
  logic [7:0] lowCond, lowHeld;
  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g++) begin : gRail
      logic [31:0] filt_ff, nxt_filt, hold_ff, nxt_hold;
      always_comb begin
        nxt_filt = 32'h0;
        nxt_hold = 32'h0;
        if (railEn_ff[g] && below92[g])
          nxt_filt = (filt_ff == FILTER_CYCLES) ? filt_ff
                                                : filt_ff + 32'h1;
        if (filt_ff == FILTER_CYCLES) nxt_hold = HOLD_CYCLES;
        else if (hold_ff != 32'h0) nxt_hold = hold_ff - 32'h1;
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          filt_ff <= 32'h0;
          hold_ff <= 32'h0;
        end else begin
          filt_ff <= nxt_filt;
          hold_ff <= nxt_hold;
        end
      end
      assign lowCond[g] = (filt_ff == FILTER_CYCLES);
      assign lowHeld[g] = lowCond[g] | (hold_ff != 32'h0);
    end
  endgenerate

  // power-good, persistence timer, faults, events and read-back
  logic [31:0] persist_ff, nxt_persist, pbCnt_ff, nxt_pbCnt;
  logic [7:0]  evt_ff, nxt_evt, rd_ff, nxt_rd;
  logic        pgOe_ff, nxt_pgOe, fault_ff, nxt_fault, irq_ff, nxt_irq;
  always_comb begin
    nxt_evt = evt_ff;
    // an open-drain pull low while any condition holds; once released,
    // a dip reaches the pin only through the filter, so glitches are ignored
    nxt_pgOe = (railEn_ff == 8'h00) |
               (pgOe_ff &
                ((railEn_ff & ~above93 & ~mask_ff) != 8'h00)) |
               ((lowHeld & ~mask_ff) != 8'h00);
    nxt_persist = (lowCond != 8'h00) ?
      ((persist_ff == PERSIST_CYCLES) ? persist_ff
                                      : persist_ff + 32'h1) : 32'h0;
    nxt_pbCnt = pbLow ? ((pbCnt_ff == PB_CLEAR_CYCLES) ? pbCnt_ff
                                                       : pbCnt_ff + 32'h1)
                      : 32'h0;
    nxt_fault = uvFault | otFault;
    // clear first so that a same-cycle event still sets its bit
    if (eventClearCmd || pbCnt_ff == PB_CLEAR_CYCLES) nxt_evt = 8'h00;
    if (persist_ff == PERSIST_CYCLES)
      nxt_evt[EVT_PG_TIMEOUT] = 1'b1;
    if (uvFault) nxt_evt[EVT_UV_STANDBY] = 1'b1;
    if (otFault) nxt_evt[EVT_OT_STANDBY] = 1'b1;
    nxt_irq = (nxt_evt == 8'h00);
    case (regAddr)
      REG_SEQ_BUCKS:   nxt_rd = seqBucks_ff;
      REG_SEQ_LINEARS: nxt_rd = seqLin_ff;
      REG_SYS_CONTROL: nxt_rd = ctrl_ff;
      REG_POWER_MASK:  nxt_rd = mask_ff;
      REG_EVENT_STAT:  nxt_rd = evt_ff;
      REG_POWER_OK:    nxt_rd = ~lowHeld;
      default:         nxt_rd = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      persist_ff <= 32'h0;
      pbCnt_ff   <= 32'h0;
      evt_ff     <= 8'h00;
      rd_ff      <= 8'h00;
      pgOe_ff    <= 1'b1;
      fault_ff   <= 1'b0;
      irq_ff     <= 1'b1;
    end else begin
      persist_ff <= nxt_persist;
      pbCnt_ff   <= nxt_pbCnt;
      evt_ff     <= nxt_evt;
      rd_ff      <= nxt_rd;
      pgOe_ff    <= nxt_pgOe;
      fault_ff   <= nxt_fault;
      irq_ff     <= nxt_irq;
    end
  end

  assign railEn       = railEn_ff;
  assign faultStandby = fault_ff;
  assign uvWarnSel    = ctrl_ff[CTRL_UV_LSB +: 3];
  assign otWarnSel    = ctrl_ff[CTRL_OT_LSB +: 2];
  assign powerGoodOe  = pgOe_ff;
  assign irq_n        = irq_ff;
  assign regRdData    = rd_ff;
endmodule // pds_sequencer

//--- hdl/pds_pkg.sv
/*
  pds_pkg: shared constants for the power-down sequencer and fault monitor.
  Assumes a 250 MHz control clock; times are kept in ns and turned into
  cycle counts here, least times rounded up.
*/
package pds_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NUM_RAILS     = 8;

  // register indices on the register port
  localparam logic [2:0] REG_SEQ_BUCKS   = 3'h0;
  localparam logic [2:0] REG_SEQ_LINEARS = 3'h1;
  localparam logic [2:0] REG_SYS_CONTROL = 3'h2;
  localparam logic [2:0] REG_POWER_MASK  = 3'h3;
  localparam logic [2:0] REG_EVENT_STAT  = 3'h4;
  localparam logic [2:0] REG_POWER_OK    = 3'h5;

  // reset values
  localparam logic [7:0] SEQ_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // field positions
  localparam int unsigned CTRL_OT_LSB = 0;
  localparam int unsigned CTRL_UV_LSB = 2;
  localparam int unsigned EVT_PG_TIMEOUT = 2;
  localparam int unsigned EVT_UV_STANDBY = 4;
  localparam int unsigned EVT_OT_STANDBY = 6;
  localparam int unsigned ALWAYS_ON_RAIL = 4;
  localparam int unsigned LINEAR_FIRST   = 5;

  // times in ns
  localparam longint unsigned STEP_NS     = 100_000_000;
  localparam longint unsigned FILTER_NS   = 50_000;
  localparam longint unsigned HOLD_NS     = 1_000_000;
  localparam longint unsigned PERSIST_NS  = 20_000_000;
  localparam longint unsigned PB_CLEAR_NS = 50_000_000;

  // cycle counts, rounded up
  localparam int unsigned STEP_CYC =
    int'((STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned FILTER_CYC =
    int'((FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned HOLD_CYC =
    int'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PERSIST_CYC =
    int'((PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PB_CLEAR_CYC =
    int'((PB_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] LAST_STEP = 2'h3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} pds_seq_t;
endpackage

//--- bench/pds_sequencer_properties.sv
/* pds_sequencer_properties: port timing checks for the sequencer.
   Assumes one clock domain; parameters are handed on by the bind. */
`timescale 1ns/1ps
module pds_sequencer_properties
  import pds_pkg::*;
#(parameter int unsigned STEP_CYCLES = 20) (
  input wire logic       mclk, rst_n, railsActive, supplyUndervoltage,
  input wire logic       dieOvertemperature, faultStandby, powerGoodOe,
  input wire logic       pushButton_n, irq_n, regWrEn, eventClearCmd,
  input wire logic [7:0] railEn, regWrData,
  input wire logic [2:0] regAddr, uvWarnSel,
  input wire logic [1:0] otWarnSel
);
  logic [7:0] bucksSh, linsSh, ctrlSh;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // shadows of written fields, so drop times and warning selects can be predicted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bucksSh <= SEQ_RESET;
      linsSh  <= SEQ_RESET;
      ctrlSh  <= CTRL_RESET;
    end else if (regWrEn) begin
      if (regAddr == REG_SEQ_BUCKS) bucksSh <= regWrData;
      if (regAddr == REG_SEQ_LINEARS) linsSh <= regWrData;
      if (regAddr == REG_SYS_CONTROL) ctrlSh <= regWrData;
    end
  end
  a_code0_drop: assert property ($fell(railsActive)
    && bucksSh == 8'h00 && linsSh[5:0] == 6'h00
    |=> (railEn & 8'hEF) == 8'h00) else $error("rails not off at once");
  a_code1_delay: assert property ($fell(railsActive)
    && bucksSh[3:2] == 2'h1 && railEn[1]
    |-> ##STEP_CYCLES railEn[1] ##1 !railEn[1])
    else $error("buck2 drop not one step late");
  // the always-on rail follows its request and is left out here
  a_no_reenable: assert property (!railsActive
    && !$past(railsActive)
    |-> ((railEn & ~$past(railEn)) & 8'hEF) == 8'h00)
    else $error("rail came on while rails-active low");
  a_uv_standby: assert property (supplyUndervoltage [*4]
    |=> faultStandby) else $error("undervoltage did not force standby");
  a_ot_standby: assert property (dieOvertemperature [*4]
    |=> faultStandby) else $error("overtemperature did not force standby");
  a_fault_release: assert property
    ((!supplyUndervoltage && !dieOvertemperature) [*4] |=> !faultStandby)
    else $error("fault stayed after sensors cleared");
  a_warn_fields: assert property (regWrEn
    && regAddr == REG_SYS_CONTROL |=> {uvWarnSel, otWarnSel} == ctrlSh[4:0])
    else $error("warning selects do not follow control write");
  // five quiet cycles cover sync and clear latency of either source
  a_irq_latched: assert property
    ((!irq_n && !eventClearCmd && pushButton_n) [*5] |=> !irq_n)
    else $error("interrupt released without a clear");
  a_pg_all_off: assert property ((railEn == 8'h00) [*3]
    |-> powerGoodOe) else $error("power-good not low with rails off");
endmodule // pds_sequencer_properties

bind pds_sequencer pds_sequencer_properties #(.STEP_CYCLES(STEP_CYCLES))
  u_pds_sequencer_properties (.mclk(mclk), .rst_n(rst_n),
  .railsActive(railsActive), .supplyUndervoltage(supplyUndervoltage),
  .dieOvertemperature(dieOvertemperature), .faultStandby(faultStandby),
  .powerGoodOe(powerGoodOe), .pushButton_n(pushButton_n), .irq_n(irq_n),
  .regWrEn(regWrEn), .eventClearCmd(eventClearCmd), .railEn(railEn),
  .regWrData(regWrData), .regAddr(regAddr), .uvWarnSel(uvWarnSel),
  .otWarnSel(otWarnSel));

//--- bench/pds_host_model.sv
/* pds_host_model: processor side that holds rails-active.
   Assumes the bench sets holdReq; output moves only on mclk. */
`timescale 1ns/1ps
module pds_host_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic holdReq,
  input  wire logic faultStandby,
  output logic      railsActive
);
  logic railsActive_ff, nxt_railsActive;
  // a hold drop and a fault end the active phase the same way
  always_comb nxt_railsActive = holdReq && !faultStandby;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) railsActive_ff <= 1'b0;
    else railsActive_ff <= nxt_railsActive;
  end
  assign railsActive = railsActive_ff;
endmodule // pds_host_model

//--- bench/testbench.sv
/* testbench: scenario tasks for the sequencer beside a host model.
   Assumes shortened timers; inputs move 1 ns after mclk rises. */
`timescale 1ns/1ps
module testbench;
  import pds_pkg::*;
  localparam int unsigned STEP = 20;
  localparam int unsigned HOLD = 8;
  logic       mclk, rst_n, holdReq, railsActive, uv, ot, faultStandby;
  logic       pgOe, pb_n, irq_n, wrEn, clr;
  logic [7:0] req, railEn, above, below, wrData, rdData;
  logic [2:0] addr, uvSel;
  logic [1:0] otSel;
  int         n_fail, tests_run, n;
  pds_host_model u_pds_host_model (.mclk(mclk), .rst_n(rst_n),
    .holdReq(holdReq), .faultStandby(faultStandby),
    .railsActive(railsActive));
  pds_sequencer #(.STEP_CYCLES(STEP), .FILTER_CYCLES(5),
    .HOLD_CYCLES(HOLD), .PERSIST_CYCLES(40), .PB_CLEAR_CYCLES(10))
    u_pds_sequencer (.mclk(mclk), .rst_n(rst_n), .railsActive(railsActive),
    .railEnReq(req), .railEn(railEn), .supplyUndervoltage(uv),
    .dieOvertemperature(ot), .faultStandby(faultStandby),
    .uvWarnSel(uvSel), .otWarnSel(otSel), .railAbove93(above),
    .railBelow92(below), .powerGoodOe(pgOe), .pushButton_n(pb_n),
    .irq_n(irq_n), .regWrEn(wrEn), .regAddr(addr), .regWrData(wrData),
    .regRdData(rdData), .eventClearCmd(clr));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // step past k edges so drives never race the sampling edge
  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // bounded wait; running out ends the run as a mismatch
  // selects the watched output: 0 power-good enable, 1 interrupt
  function automatic logic pick(input bit w);
    return w ? irq_n : pgOe;
  endfunction
  task automatic waitSig(input bit w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      tick();
      n++;
    end
    if (pick(w) !== v) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    tick();
    wrEn = 1'b0;
    tick();
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] m, logic [7:0] e);
    addr = a;
    tick();
    chk(rdData & m, e, "read");
  endtask
  task automatic pulseClr();
    clr = 1'b1;
    tick();
    clr = 1'b0;
    tick(3);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 4; a++) rd(3'(a), 8'hFF, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'hFF, 8'h00);
    wr(REG_SEQ_BUCKS, 8'hE4);
    rd(REG_SEQ_BUCKS, 8'hFF, 8'hE4);
    wr(REG_SEQ_LINEARS, 8'hFF);
    rd(REG_SEQ_LINEARS, 8'hFF, 8'h3F);
    wr(REG_SYS_CONTROL, 8'h1B);
    chk({3'h0, uvSel, otSel}, 8'h1B, "warn selects");
    wr(REG_SEQ_BUCKS, 8'h00);
    wr(REG_SEQ_LINEARS, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pg();
    logic seen;
    waitSig(1'b0, 1'b0, 30);
    below = 8'h02;
    tick(3);
    below = 8'h00;
    seen = 1'b0;
    repeat (12) begin
      tick();
      seen = seen | pgOe;
    end
    chk({7'h0, seen}, 8'h00, "glitch filtered");
    below = 8'h02;
    above = 8'hFD;
    waitSig(1'b0, 1'b1, 20);
    chk({7'h0, n >= 5}, 8'h01, "filter length");
    waitSig(1'b1, 1'b0, 60);
    rd(REG_EVENT_STAT, 8'hFF, 8'h04);
    below = 8'h00;
    above = 8'hFF;
    waitSig(1'b0, 1'b0, 40);
    chk({7'h0, n >= HOLD}, 8'h01, "hold after clear");
    pulseClr();
    chk({7'h0, irq_n}, 8'h01, "clear command");
    wr(REG_POWER_MASK, 8'h01);
    below = 8'h01;
    above = 8'hFE;
    tick(20);
    chk({7'h0, pgOe}, 8'h00, "masked rail");
    rd(REG_POWER_OK, 8'h01, 8'h00);
    below = 8'h00;
    above = 8'hFF;
    wr(REG_POWER_MASK, 8'h00);
    req = 8'h00;
    tick(6);
    chk({7'h0, pgOe}, 8'h01, "all rails off");
    req = 8'h7F;
    $display("test power-good done");
  endtask
  task automatic t_fault();
    for (int k = 0; k < 2; k++) begin
      uv = (k == 0);
      ot = (k == 1);
      tick(8);
      chk({7'h0, faultStandby}, 8'h01, "standby");
      chk(railEn & 8'hEF, 8'h00, "fault shutdown");
      uv = 1'b0;
      ot = 1'b0;
      tick(8);
      chk({7'h0, faultStandby}, 8'h00, "fault cleared");
    end
    rd(REG_EVENT_STAT, 8'h50, 8'h50);
    pulseClr();
    rd(REG_EVENT_STAT, 8'hFF, 8'h00);
    ot = 1'b1;
    tick(6);
    ot = 1'b0;
    pb_n = 1'b0;
    tick(20);
    pb_n = 1'b1;
    tick(3);
    chk({7'h0, irq_n}, 8'h01, "button clear");
    $display("test faults done");
  endtask
  task automatic t_seq();
    int cd[8] = '{0, 1, 2, 3, 0, 0, 1, 2};
    logic [7:0] e;
    wr(REG_SEQ_BUCKS, 8'hE4);
    wr(REG_SEQ_LINEARS, 8'h24);
    tick(20);
    holdReq = 1'b0;
    tick(2);
    for (int c = 1; c <= 3 * STEP + 5; c++) begin
      tick();
      // a code n rail is still on for n*STEP-1 looks, off from the next
      for (int i = 0; i < 8; i++)
        e[i] = req[i] && (i == 4 || c < cd[i] * STEP);
      chk(railEn, e, "sequence down");
    end
    holdReq = 1'b1;
    $display("test sequence done");
  endtask
  initial begin
    {rst_n, uv, ot, wrEn, clr} = 5'h00;
    holdReq = 1'b1;
    pb_n = 1'b1;
    req = 8'h7F;
    above = 8'hFF;
    below = 8'h00;
    addr = 3'h0;
    wrData = 8'h00;
    n_fail = 0;
    tests_run = 0;
    tick(12);
    rst_n = 1'b1;
    t_regs();
    t_pg();
    t_fault();
    t_seq();
    wrap_up();
  end
endmodule // testbench
